// ===== alu_defs.svh
// Purpose: Constants of the arithmetic and logic datapath
// Assumes: Included by bare name, once per compile unit
// Notes:   Flag positions, address limits, reset values, cycle counts
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// Flag positions in the flag register
`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_N          2
`define FLAG_V          3
`define FLAG_S          4
`define FLAG_H          5
`define FLAG_W          6

// Reset values
`define FLAGS_RST       6'h00
`define STAT_RST        8'h00
`define RESULT_RST      8'h00

// Bit set and clear reach only the lower I/O range
`define IO_ADDR_W       6
`define IO_BIT_LO_ADDR  6'h00
`define IO_BIT_HI_ADDR  6'h1f
// Address of the block's own write-one-to-clear status register
`define STAT_IO_ADDR    6'h08

// Cycle counts
`define CLK_BYTE_OP     1
`define CLK_WORD_OP     2

`endif

// ===== alu_pkg.sv
// Purpose: Types of the arithmetic and logic datapath
// Assumes: Nothing beyond the language
// Notes:   Operation codes and sequencer states
package alu_pkg;

    typedef enum logic [3:0] {
        op_add_reg,
        op_add_carry_reg,
        op_add_imm_word,
        op_sub_reg,
        op_sub_imm,
        op_sub_imm_word,
        op_sub_carry_reg,
        op_sub_carry_imm,
        op_and_reg,
        op_and_imm,
        op_or_reg,
        op_or_imm,
        op_set_mask_bits,
        op_clear_mask_bits,
        op_io_bit_clear,
        op_io_bit_set
    } alu_op_t;

    typedef enum logic [0:0] {
        st_idle,
        st_word_hi
    } seq_state_t;

endpackage : alu_pkg

// ===== alu_byte_addsub.sv
// Purpose: 8-bit adder and subtractor with carry, half carry and overflow
// Assumes: Purely combinational; carry in means borrow in when subtracting
// Notes:   Carry out reads as borrow when subtracting
`timescale 1ns/10ps

module alu_byte_addsub (
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    input  wire logic       sub,
    output wire logic [7:0] sum,
    output wire logic       carry,
    output wire logic       half,
    output wire logic       ovf
);
    wire logic [7:0] b_eff;
    wire logic       c_eff;
    wire logic [8:0] full;
    wire logic [4:0] nib;

    // Subtract as a + ~b + ~borrow, then invert the carries to get borrows
    assign b_eff = sub ? ~b : b;
    assign c_eff = sub ? ~cin : cin;
    assign full  = {1'b0, a} + {1'b0, b_eff} + {8'h00, c_eff};
    assign nib   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
    assign sum   = full[7:0];
    assign carry = full[8] ^ sub;
    assign half  = nib[4] ^ sub;
    assign ovf   = (a[7] == b_eff[7]) && (full[7] != a[7]);

endmodule : alu_byte_addsub

// ===== io_bit_rmw.sv
// Purpose: Write data for a single-bit set or clear on an I/O register
// Assumes: Read data is the whole register as it stands
// Notes:   Every other bit is written back as read
`timescale 1ns/10ps

`include "alu_defs.svh"

module io_bit_rmw (
    input  wire logic [5:0] addr,
    input  wire logic [2:0] bit_sel,
    input  wire logic       set_bit,
    input  wire logic [7:0] rdata,
    output wire logic [7:0] wdata,
    output wire logic       in_range
);
    wire logic [7:0] bit_mask;

    assign bit_mask = 8'h01 << bit_sel;
    // Whole register goes back, so a flag read as one is written as one
    assign wdata    = set_bit ? (rdata | bit_mask) : (rdata & ~bit_mask);
    assign in_range = (addr >= `IO_BIT_LO_ADDR) && (addr <= `IO_BIT_HI_ADDR);

endmodule : io_bit_rmw

// ===== alu_arith_logic_ops.sv
// Purpose: Arithmetic and logic datapath with flags and I/O bit access
// Assumes: All inputs synchronous to CLK_SYS; operands valid with OP_VALID
// Notes:   Word operations hold OP_READY low for their second clock
`timescale 1ns/10ps

`include "alu_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Add, add with carry: ZCNVH, one clock
// - Word add immediate: ZCNVS, two clocks
// - Subtract register or immediate: ZCNVH, one clock
// - Word subtract immediate: ZCNVS, two clocks
// - Subtract register with carry: ZCNVH, one clock
// - Subtract immediate with carry: ZCNVH, one clock
// - AND register or immediate: ZNV, one clock
// - OR register or immediate: ZNV, one clock
// - Set masked bits: ZNV, one clock
// - Clear masked bits: ZNV, one clock
// - Status flags clear on written one
// - I/O bit ops rewrite the whole register
// - I/O bit ops reach addresses 00 to 1F
module alu_arith_logic_ops
    import alu_pkg::*;
(
    input  wire logic          CLK_SYS,
    input  wire logic          RST,
    input  wire logic          CE,
    input  wire logic          OP_VALID,
    input  wire alu_op_t       OP_CODE,
    input  wire logic [7:0]    OPA,
    input  wire logic [7:0]    OPA_HI,
    input  wire logic [7:0]    OPB,
    input  wire logic [7:0]    IMM,
    input  wire logic [5:0]    IO_ADDR,
    input  wire logic [2:0]    IO_BIT,
    input  wire logic [7:0]    IO_RDATA,
    input  wire logic [7:0]    STAT_EVENT,
    output logic               OP_READY,
    output logic               RES_VALID,
    output logic [7:0]         RESULT,
    output logic [7:0]         RESULT_HI,
    output logic [5:0]         FLAGS,
    output logic               IO_WE,
    output logic [5:0]         IO_WADDR,
    output logic [7:0]         IO_WDATA,
    output logic               IO_ERR,
    output logic [7:0]         STATUS_FLAGS
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    seq_state_t      state_r;
    seq_state_t      state_nxt;
    logic [7:0]      hi_r;
    logic            wcarry_r;
    logic            wsub_r;
    logic [5:0]      flags_nxt;

    wire logic       accept;
    wire logic       in_hi;
    wire logic       is_imm;
    wire logic       is_word;
    wire logic       is_sub;
    wire logic       use_c;
    wire logic       is_arith;
    wire logic       is_logic;
    wire logic       is_io;
    wire logic [7:0] b_sel;
    wire logic [7:0] logic_res;
    wire logic [7:0] core_a;
    wire logic [7:0] core_b;
    wire logic       core_cin;
    wire logic       core_sub;
    wire logic [7:0] core_sum;
    wire logic       core_c;
    wire logic       core_h;
    wire logic       core_v;
    wire logic [7:0] io_rd;
    wire logic [7:0] io_wd;
    wire logic       io_ok;
    wire logic       stat_hit;
    wire logic [7:0] stat_clr;

    assign accept   = CE && OP_VALID && OP_READY;
    assign in_hi    = (state_r == st_word_hi);
    assign is_word  = (OP_CODE == op_add_imm_word) || (OP_CODE == op_sub_imm_word);
    assign is_imm   = (OP_CODE == op_sub_imm) || (OP_CODE == op_sub_carry_imm) || (OP_CODE == op_and_imm) ||
                      (OP_CODE == op_or_imm) || (OP_CODE == op_set_mask_bits) || (OP_CODE == op_clear_mask_bits) ||
                      is_word;
    assign is_sub   = (OP_CODE == op_sub_reg) || (OP_CODE == op_sub_imm) || (OP_CODE == op_sub_imm_word) ||
                      (OP_CODE == op_sub_carry_reg) || (OP_CODE == op_sub_carry_imm);
    assign use_c    = (OP_CODE == op_add_carry_reg) || (OP_CODE == op_sub_carry_reg) ||
                      (OP_CODE == op_sub_carry_imm);
    // Word subtract is not a byte op: H must survive, flags wait for the high half
    assign is_arith = (OP_CODE == op_add_reg) || (OP_CODE == op_add_carry_reg) || (is_sub && !is_word);
    assign is_io    = (OP_CODE == op_io_bit_clear) || (OP_CODE == op_io_bit_set);
    assign is_logic = !is_arith && !is_io && !is_word;
    assign b_sel    = is_imm ? IMM : OPB;

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic core, shared by byte ops and both halves of a word op
    // The high half rides the low half's carry, hence the second clock
    assign core_a   = in_hi ? hi_r : OPA;
    assign core_b   = in_hi ? 8'h00 : b_sel;
    assign core_cin = in_hi ? wcarry_r : (use_c && FLAGS[`FLAG_C]);
    assign core_sub = in_hi ? wsub_r : is_sub;

    alu_byte_addsub u_addsub (
        .a     (core_a),
        .b     (core_b),
        .cin   (core_cin),
        .sub   (core_sub),
        .sum   (core_sum),
        .carry (core_c),
        .half  (core_h),
        .ovf   (core_v)
    );

    // Register and immediate forms share one path
    assign logic_res = (OP_CODE == op_and_reg || OP_CODE == op_and_imm) ? (OPA & b_sel) :
                       (OP_CODE == op_clear_mask_bits)                   ? (OPA & ~IMM) :
                       (OPA | b_sel);

    ////////////////////////////////////////////////////////////////////////////
    // I/O bit access; the own status register answers at its address
    assign stat_hit = (IO_ADDR == `STAT_IO_ADDR);
    assign io_rd    = stat_hit ? STATUS_FLAGS : IO_RDATA;

    io_bit_rmw u_rmw (
        .addr     (IO_ADDR),
        .bit_sel  (IO_BIT),
        .set_bit  (OP_CODE == op_io_bit_set),
        .rdata    (io_rd),
        .wdata    (io_wd),
        .in_range (io_ok)
    );

    // Write one clears; a new event in the same cycle still sets
    assign stat_clr = (accept && is_io && io_ok && stat_hit) ? io_wd : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Flags
    always_comb begin
        flags_nxt = FLAGS;
        if (in_hi) begin
            flags_nxt[`FLAG_Z] = (core_sum == 8'h00) && (RESULT == 8'h00);
            flags_nxt[`FLAG_C] = core_c;
            flags_nxt[`FLAG_N] = core_sum[7];
            flags_nxt[`FLAG_V] = core_v;
            flags_nxt[`FLAG_S] = core_sum[7] ^ core_v;
        end else if (accept && is_arith) begin
            flags_nxt[`FLAG_Z] = (core_sum == 8'h00);
            flags_nxt[`FLAG_C] = core_c;
            flags_nxt[`FLAG_N] = core_sum[7];
            flags_nxt[`FLAG_V] = core_v;
            flags_nxt[`FLAG_H] = core_h;
        end else if (accept && is_logic) begin
            flags_nxt[`FLAG_Z] = (logic_res == 8'h00);
            flags_nxt[`FLAG_N] = logic_res[7];
            flags_nxt[`FLAG_V] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        case (state_r)
            st_idle:    state_nxt = (accept && is_word) ? st_word_hi : st_idle;
            st_word_hi: state_nxt = st_idle;
            default:    state_nxt = st_idle;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_r  <= st_idle;
            OP_READY <= 1'b1;
            hi_r     <= `RESULT_RST;
            wcarry_r <= 1'b0;
            wsub_r   <= 1'b0;
        end else if (CE) begin
            state_r  <= state_nxt;
            OP_READY <= (state_nxt == st_idle);
            if (accept && is_word) begin
                hi_r     <= OPA_HI;
                wcarry_r <= core_c;
                wsub_r   <= is_sub;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Results
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RES_VALID <= 1'b0;
            RESULT    <= `RESULT_RST;
            RESULT_HI <= `RESULT_RST;
            FLAGS     <= `FLAGS_RST;
        end else if (CE) begin
            RES_VALID <= in_hi || (accept && !is_word && !is_io);
            FLAGS     <= flags_nxt;
            if (in_hi) begin
                RESULT_HI <= core_sum;
            end else if (accept && !is_io) begin
                RESULT <= is_logic ? logic_res : core_sum;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            IO_WE        <= 1'b0;
            IO_WADDR     <= `IO_BIT_LO_ADDR;
            IO_WDATA     <= 8'h00;
            IO_ERR       <= 1'b0;
            STATUS_FLAGS <= `STAT_RST;
        end else if (CE) begin
            // Out-of-range bit ops are refused, never written
            IO_WE        <= accept && is_io && io_ok;
            IO_ERR       <= accept && is_io && !io_ok;
            STATUS_FLAGS <= (STATUS_FLAGS & ~stat_clr) | STAT_EVENT;
            if (accept && is_io) begin
                IO_WADDR <= IO_ADDR;
                IO_WDATA <= io_wd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Second clock only counts when enabled; a frozen core may stretch it
    sequence s_word_issue;
        accept && is_word ##1 CE;
    endsequence

    sequence s_word_finish;
        RES_VALID && OP_READY;
    endsequence

    property p_add_result;
        @(posedge CLK_SYS) disable iff (RST)
        (accept && OP_CODE == op_add_reg) |=> RES_VALID && RESULT == 8'($past(OPA) + $past(OPB));
    endproperty
    a_add_result: assert property (p_add_result) else $error("add result wrong");

    property p_sub_borrow;
        @(posedge CLK_SYS) disable iff (RST)
        (accept && OP_CODE == op_sub_reg) |=> RESULT == 8'($past(OPA) - $past(OPB)) &&
            FLAGS[`FLAG_C] == ($past(OPB) > $past(OPA));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow) else $error("subtract result or borrow wrong");

    property p_sbc_imm;
        @(posedge CLK_SYS) disable iff (RST)
        (accept && OP_CODE == op_sub_carry_imm) |=>
            RESULT == 8'($past(OPA) - $past(IMM) - {7'h00, $past(FLAGS[`FLAG_C])});
    endproperty
    a_sbc_imm: assert property (p_sbc_imm) else $error("subtract with carry wrong");

    property p_word_two_clk;
        @(posedge CLK_SYS) disable iff (RST)
        s_word_issue |-> !RES_VALID && !OP_READY ##1 s_word_finish;
    endproperty
    a_word_two_clk: assert property (p_word_two_clk) else $error("word op not two clocks");

    property p_word_sign;
        @(posedge CLK_SYS) disable iff (RST)
        (in_hi && CE) |=> FLAGS[`FLAG_S] == (FLAGS[`FLAG_N] ^ FLAGS[`FLAG_V]) && FLAGS[`FLAG_N] == RESULT_HI[7];
    endproperty
    a_word_sign: assert property (p_word_sign) else $error("sign flag not N xor V");

    property p_logic_keeps;
        @(posedge CLK_SYS) disable iff (RST)
        (accept && is_logic) |=> !FLAGS[`FLAG_V] && $stable(FLAGS[`FLAG_C]) && $stable(FLAGS[`FLAG_H]) &&
            $stable(FLAGS[`FLAG_S]);
    endproperty
    a_logic_keeps: assert property (p_logic_keeps) else $error("logic op touched other flags");

    property p_clear_mask;
        @(posedge CLK_SYS) disable iff (RST)
        (accept && OP_CODE == op_clear_mask_bits) |=> (RESULT & $past(IMM)) == 8'h00 &&
            FLAGS[`FLAG_Z] == (RESULT == 8'h00);
    endproperty
    a_clear_mask: assert property (p_clear_mask) else $error("masked bits not cleared");

    property p_io_range;
        @(posedge CLK_SYS) disable iff (RST)
        (accept && is_io) |=> (IO_WE == ($past(IO_ADDR) <= `IO_BIT_HI_ADDR)) && (IO_ERR != IO_WE);
    endproperty
    a_io_range: assert property (p_io_range) else $error("I/O range check wrong");

    property p_set_wins;
        @(posedge CLK_SYS) disable iff (RST)
        CE |=> (STATUS_FLAGS & $past(STAT_EVENT)) == $past(STAT_EVENT);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status event lost");

endmodule : alu_arith_logic_ops

// ===== tb.sv
// Purpose: Self-checking bench for the arithmetic and logic datapath
// Assumes: Expected results come from a small reference inside the bench
// Notes:   Inputs change 1 ns after the rising edge; no random stimulus
`timescale 1ns/10ps

`include "alu_defs.svh"

module tb
    import alu_pkg::*;
;
    logic        CLK_SYS, RST, CE, OP_VALID;
    alu_op_t     OP_CODE;
    logic [7:0]  OPA, OPA_HI, OPB, IMM, IO_RDATA, STAT_EVENT;
    logic [5:0]  IO_ADDR;
    logic [2:0]  IO_BIT;
    logic        OP_READY, RES_VALID, IO_WE, IO_ERR;
    logic [7:0]  RESULT, RESULT_HI, IO_WDATA, STATUS_FLAGS;
    logic [5:0]  FLAGS, IO_WADDR;
    int          err_count, compares, cycles;
    logic [5:0]  model_flags;
    logic [7:0]  model_res;

    alu_arith_logic_ops i_alu_arith_logic_ops (.CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .OP_VALID(OP_VALID),
        .OP_CODE(OP_CODE), .OPA(OPA), .OPA_HI(OPA_HI), .OPB(OPB), .IMM(IMM), .IO_ADDR(IO_ADDR),
        .IO_BIT(IO_BIT), .IO_RDATA(IO_RDATA), .STAT_EVENT(STAT_EVENT), .OP_READY(OP_READY),
        .RES_VALID(RES_VALID), .RESULT(RESULT), .RESULT_HI(RESULT_HI), .FLAGS(FLAGS), .IO_WE(IO_WE),
        .IO_WADDR(IO_WADDR), .IO_WDATA(IO_WDATA), .IO_ERR(IO_ERR), .STATUS_FLAGS(STATUS_FLAGS));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    task automatic complete_run;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    // Ceiling well above the roughly 60 cycles the scenarios need
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    ////////////////////////////////////////////////////////////////////////////////
    // Reference byte result: {flags, result}
    function automatic logic [13:0] ref_byte(input alu_op_t op, input logic [7:0] a, input logic [7:0] s,
                                             input logic [5:0] f);
        logic [8:0] w;
        logic [4:0] h;
        logic [7:0] r;
        logic       sub, ci, ar;
        logic [5:0] n;
        sub = op inside {op_sub_reg, op_sub_imm, op_sub_carry_reg, op_sub_carry_imm};
        ar  = sub || op inside {op_add_reg, op_add_carry_reg};
        ci  = (op inside {op_add_carry_reg, op_sub_carry_reg, op_sub_carry_imm}) ? f[`FLAG_C] : 1'b0;
        w   = sub ? {1'b0, a} - {1'b0, s} - 9'(ci) : {1'b0, a} + {1'b0, s} + 9'(ci);
        h   = sub ? {1'b0, a[3:0]} - {1'b0, s[3:0]} - 5'(ci) : {1'b0, a[3:0]} + {1'b0, s[3:0]} + 5'(ci);
        case (op)
            op_and_reg, op_and_imm:           r = a & s;
            op_or_reg, op_or_imm, op_set_mask_bits: r = a | s;
            op_clear_mask_bits:               r = a & ~s;
            default:                          r = w[7:0];
        endcase
        n = f;
        n[`FLAG_Z] = (r == 8'h00);
        n[`FLAG_N] = r[7];
        n[`FLAG_V] = 1'b0;
        if (ar) begin
            n[`FLAG_C] = w[8];
            n[`FLAG_H] = h[4];
            n[`FLAG_V] = sub ? (a[7] != s[7]) && (r[7] != a[7]) : (a[7] == s[7]) && (r[7] != a[7]);
        end
        return {n, r};
    endfunction : ref_byte

    // Leaves OP_VALID high so calls run back to back; the unused source gets the inverse
    task automatic run_byte(input alu_op_t op, input logic [7:0] a, input logic [7:0] s);
        logic [13:0] e;
        logic        rf;
        rf = op inside {op_add_reg, op_add_carry_reg, op_sub_reg, op_sub_carry_reg, op_and_reg, op_or_reg};
        e  = ref_byte(op, a, s, model_flags);
        OP_VALID = 1'b1;
        OP_CODE  = op;
        OPA      = a;
        OPB      = rf ? s : ~s;
        IMM      = rf ? ~s : s;
        @(posedge CLK_SYS); #1;
        check("res_valid", 16'(RES_VALID), 16'h1);
        check("result", 16'(RESULT), 16'(e[7:0]));
        check("flags", 16'(FLAGS), 16'(e[13:8]));
        model_flags = e[13:8];
        model_res   = e[7:0];
    endtask : run_byte

    task automatic idle;
        OP_VALID = 1'b0;
        @(posedge CLK_SYS); #1;
        check("res_valid_drop", 16'(RES_VALID), 16'h0);
    endtask : idle

    task automatic t_arith;
        run_byte(op_add_reg, 8'hff, 8'h01);
        run_byte(op_add_carry_reg, 8'h10, 8'h20);
        run_byte(op_add_reg, 8'h0f, 8'h01);
        run_byte(op_add_reg, 8'h7f, 8'h01);
        run_byte(op_sub_reg, 8'h10, 8'h20);
        run_byte(op_sub_carry_reg, 8'h50, 8'h10);
        run_byte(op_sub_imm, 8'h80, 8'h01);
        run_byte(op_sub_carry_imm, 8'h00, 8'h00);
        run_byte(op_sub_reg, 8'h13, 8'h04);
        run_byte(op_sub_carry_imm, 8'h05, 8'h05);
        idle();
    endtask : t_arith

    task automatic t_logic;
        run_byte(op_add_reg, 8'hff, 8'h01);
        run_byte(op_and_reg, 8'hf0, 8'h3c);
        run_byte(op_and_imm, 8'h0f, 8'hf0);
        run_byte(op_or_reg, 8'h81, 8'h02);
        run_byte(op_or_imm, 8'h00, 8'h00);
        run_byte(op_set_mask_bits, 8'h01, 8'h80);
        run_byte(op_clear_mask_bits, 8'hff, 8'h0f);
        run_byte(op_clear_mask_bits, 8'h0f, 8'h0f);
        idle();
    endtask : t_logic

    ////////////////////////////////////////////////////////////////////////////////
    // A byte request is held up through the second clock; it must be ignored
    task automatic run_word(input alu_op_t op, input logic [15:0] a, input logic [7:0] k);
        logic [16:0] w;
        logic [5:0]  n;
        logic        sub;
        sub = (op == op_sub_imm_word);
        w   = sub ? {1'b0, a} - {9'h0, k} : {1'b0, a} + {9'h0, k};
        n   = model_flags;
        n[`FLAG_C] = w[16];
        n[`FLAG_Z] = (w[15:0] == 16'h0000);
        n[`FLAG_N] = w[15];
        n[`FLAG_V] = sub ? a[15] & ~w[15] : ~a[15] & w[15];
        n[`FLAG_S] = n[`FLAG_N] ^ n[`FLAG_V];
        OP_VALID = 1'b1;
        OP_CODE  = op;
        OPA      = a[7:0];
        OPA_HI   = a[15:8];
        IMM      = k;
        OPB      = ~k;
        @(posedge CLK_SYS); #1;
        OP_CODE = op_and_reg;
        OPA     = 8'hff;
        OPB     = 8'hff;
        check("ready_mid", 16'(OP_READY), 16'h0);
        check("valid_mid", 16'(RES_VALID), 16'h0);
        check("low_mid", 16'(RESULT), 16'(w[7:0]));
        @(posedge CLK_SYS); #1;
        OP_VALID = 1'b0;
        check("word_valid", 16'(RES_VALID), 16'h1);
        check("word_ready", 16'(OP_READY), 16'h1);
        check("word_res", {RESULT_HI, RESULT}, w[15:0]);
        check("word_flags", 16'(FLAGS), 16'(n));
        @(posedge CLK_SYS); #1;
        check("refused_op", {7'h0, RES_VALID, RESULT}, 16'(w[7:0]));
        model_flags = n;
        model_res   = w[7:0];
    endtask : run_word

    task automatic t_word;
        run_word(op_add_imm_word, 16'hffff, 8'h01);
        run_word(op_add_imm_word, 16'h7fff, 8'h80);
        run_word(op_add_imm_word, 16'h12f0, 8'hff);
        run_word(op_sub_imm_word, 16'h0000, 8'h01);
        run_word(op_sub_imm_word, 16'h8000, 8'h01);
        run_word(op_sub_imm_word, 16'h0140, 8'h40);
    endtask : t_word

    ////////////////////////////////////////////////////////////////////////////////
    // At the status address the bus read data is inverted, so it must not be used
    task automatic run_io(input logic setb, input logic [5:0] ad, input logic [2:0] bn, input logic [7:0] rd);
        logic [7:0] wd;
        logic       ok;
        wd = setb ? rd | (8'h01 << bn) : rd & ~(8'h01 << bn);
        ok = (ad <= `IO_BIT_HI_ADDR);
        OP_VALID = 1'b1;
        OP_CODE  = setb ? op_io_bit_set : op_io_bit_clear;
        IO_ADDR  = ad;
        IO_BIT   = bn;
        IO_RDATA = (ad == `STAT_IO_ADDR) ? ~rd : rd;
        @(posedge CLK_SYS); #1;
        check("io_we", 16'(IO_WE), 16'(ok));
        check("io_err", 16'(IO_ERR), 16'(!ok));
        if (ok) begin
            check("io_wr", {2'b00, IO_WADDR, IO_WDATA}, {2'b00, ad, wd});
        end
    endtask : run_io

    task automatic t_io;
        run_io(1'b1, 6'h05, 3'd2, 8'h81);
        run_io(1'b0, 6'h1f, 3'd7, 8'hff);
        run_io(1'b1, 6'h20, 3'd0, 8'h00);
        run_io(1'b0, 6'h3f, 3'd1, 8'h55);
        run_io(1'b1, 6'h00, 3'd0, 8'h00);
        idle();
        STAT_EVENT = 8'h24;
        @(posedge CLK_SYS); #1;
        STAT_EVENT = 8'h00;
        check("stat_set", 16'(STATUS_FLAGS), 16'h24);
        run_io(1'b1, `STAT_IO_ADDR, 3'd0, 8'h24);
        check("stat_rmw", 16'(STATUS_FLAGS), 16'h00);
        idle();
        STAT_EVENT = 8'h81;
        @(posedge CLK_SYS); #1;
        STAT_EVENT = 8'h00;
        run_io(1'b0, `STAT_IO_ADDR, 3'd0, 8'h81);
        check("stat_zero_kept", 16'(STATUS_FLAGS), 16'h01);
        // Event on bit 0 while the rewrite clears it: the set must win
        STAT_EVENT = 8'h01;
        run_io(1'b1, `STAT_IO_ADDR, 3'd1, 8'h01);
        STAT_EVENT = 8'h00;
        check("stat_set_wins", 16'(STATUS_FLAGS), 16'h01);
        idle();
    endtask : t_io

    // Clock enable low must freeze a pending request
    task automatic t_ce;
        CE       = 1'b0;
        OP_VALID = 1'b1;
        OP_CODE  = op_add_reg;
        OPA      = 8'h01;
        OPB      = 8'h01;
        repeat (2) @(posedge CLK_SYS);
        #1;
        check("frozen", {7'h0, RES_VALID, RESULT}, 16'(model_res));
        CE = 1'b1;
        @(posedge CLK_SYS); #1;
        OP_VALID = 1'b0;
        check("thawed", {7'h0, RES_VALID, RESULT}, 16'h0102);
    endtask : t_ce

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        compares = 0;
        cycles = 0;
        model_flags = `FLAGS_RST;
        model_res = `RESULT_RST;
        RST = 1'b1;
        CE = 1'b1;
        OP_VALID = 1'b0;
        OP_CODE = op_add_reg;
        {OPA, OPA_HI, OPB, IMM, IO_RDATA, STAT_EVENT} = '0;
        IO_ADDR = 6'h00;
        IO_BIT = 3'h0;
        repeat (8) @(posedge CLK_SYS);
        #1;
        RST = 1'b0;
        check("rst_out", {OP_READY, RES_VALID, IO_WE, IO_ERR, 6'h0, FLAGS}, 16'h8000);
        check("rst_res", {RESULT_HI, RESULT}, 16'h0000);
        check("rst_stat", 16'(STATUS_FLAGS), 16'(`STAT_RST));
        t_arith();
        t_logic();
        t_word();
        t_io();
        t_ce();
        complete_run();
    end

endmodule : tb
